// ### hdl/dec_skip_defs.vh
`ifndef DEC_SKIP_DEFS_VH
`define DEC_SKIP_DEFS_VH
// ----------------------------------------
// operation codes on op_in
// ----------------------------------------
`define OP_NONE 2'h0
`define OP_DEC_MEM_SKIP_ZERO 2'h1
`define OP_DEC_TO_ACC_SKIP_ZERO 2'h2
`define OP_SUB_BORROW_TO_MEM 2'h3
// ----------------------------------------
// widths and constants
// ----------------------------------------
`define DATA_W 8
`define ADDR_W 8
`define BYTE_ZERO 8'h00
`define BYTE_ONE 8'h01
`define ACC_RESET 8'h00
`define NIBBLE_ZERO 4'h0
`define BIT_LOW 1'b0
`define BIT_HIGH 1'b1
// ----------------------------------------
// bit positions
// ----------------------------------------
`define SIGN_BIT 7
`define NIBBLE_MSB 3
`define NIBBLE_CARRY 4
`define CARRY_BIT 8
`endif

// ### hdl/dec_sub_alu.v
`timescale 1ns/1ns
`include "dec_skip_defs.vh"
// ----------------------------------------
// arithmetic for decrement and subtract-with-borrow
// ----------------------------------------
module dec_sub_alu (
  input wire [7:0] mem_val_in,
  input wire [7:0] acc_val_in,
  input wire carry_in,
  output wire [7:0] dec_out,
  output wire dec_zero_out,
  output wire [7:0] sub_out,
  output wire sub_carry_out,
  output wire sub_half_carry_out,
  output wire sub_ovf_out
);
  wire [8:0] sub_full;
  wire [4:0] sub_low;

  assign dec_out = mem_val_in - `BYTE_ONE;
  assign dec_zero_out = (dec_out == `BYTE_ZERO);
  // acc + ~m + c: carry out set means no borrow
  assign sub_full = {`BIT_LOW, acc_val_in} + {`BIT_LOW, ~mem_val_in}
    + {`BYTE_ZERO, carry_in};
  assign sub_low = {`BIT_LOW, acc_val_in[`NIBBLE_MSB:0]} + {`BIT_LOW, ~mem_val_in[`NIBBLE_MSB:0]}
    + {`NIBBLE_ZERO, carry_in};
  assign sub_out = sub_full[`SIGN_BIT:0];
  assign sub_carry_out = sub_full[`CARRY_BIT];
  assign sub_half_carry_out = sub_low[`NIBBLE_CARRY];
  assign sub_ovf_out = (acc_val_in[`SIGN_BIT] != mem_val_in[`SIGN_BIT])
    && (sub_full[`SIGN_BIT] != acc_val_in[`SIGN_BIT]);
endmodule

// ### hdl/decrement_skip_execution.v
`timescale 1ns/1ns
`include "dec_skip_defs.vh"
// Contract
// - memory decrement-skip reads the byte, subtracts one, writes it back.
// - zero result discards the prefetched instruction; two machine cycles total.
// - nonzero result continues without flush; one machine cycle.
// - accumulator variant puts result in accumulator; memory untouched; same skip.
// - subtract-with-borrow takes acc minus memory minus not-carry into memory.
module decrement_skip_execution (
  input wire core_clk_in,
  input wire rst_n_in,
  input wire op_valid_in,
  input wire [1:0] op_in,
  input wire [7:0] addr_in,
  input wire [7:0] mem_rdata_in,
  input wire carry_in,
  output reg [7:0] accumulator_reg_out,
  output reg mem_we_out,
  output reg [7:0] mem_addr_out,
  output reg [7:0] mem_wdata_out,
  output reg flush_out,
  output reg busy_out,
  output reg flag_we_out,
  output reg flag_z_out,
  output reg flag_c_out,
  output reg flag_ac_out,
  output reg flag_ov_out
);
  // ----------------------------------------
  // sequencer states
  // ----------------------------------------
  localparam ST_EXEC = 1'b0;
  localparam ST_IDLE = 1'b1;

  // ----------------------------------------
  // operation decode
  // ----------------------------------------
  // shared by the sequencer and the data paths, so the op map lives in one place
  function op_dec_skip(input [1:0] op);
    case (op)
      `OP_DEC_MEM_SKIP_ZERO: op_dec_skip = `BIT_HIGH;
      `OP_DEC_TO_ACC_SKIP_ZERO: op_dec_skip = `BIT_HIGH;
      default: op_dec_skip = `BIT_LOW;
    endcase
  endfunction

  function op_mem_write(input [1:0] op);
    case (op)
      `OP_DEC_MEM_SKIP_ZERO: op_mem_write = `BIT_HIGH;
      `OP_SUB_BORROW_TO_MEM: op_mem_write = `BIT_HIGH;
      default: op_mem_write = `BIT_LOW;
    endcase
  endfunction

  function op_flag_write(input [1:0] op);
    case (op)
      `OP_SUB_BORROW_TO_MEM: op_flag_write = `BIT_HIGH;
      default: op_flag_write = `BIT_LOW;
    endcase
  endfunction

  // ----------------------------------------
  // internal signals
  // ----------------------------------------
  wire [7:0] dec_val;
  wire dec_zero;
  wire [7:0] sub_val;
  wire sub_c;
  wire sub_ac;
  wire sub_ov;
  wire take;
  wire skip_hit;
  reg state_r;
  reg state_nxt;
  reg [7:0] acc_nxt;
  reg mem_we_nxt;
  reg [7:0] mem_addr_nxt;
  reg [7:0] mem_wdata_nxt;
  reg flush_nxt;
  reg busy_nxt;
  reg flag_we_nxt;
  reg flag_z_nxt;
  reg flag_c_nxt;
  reg flag_ac_nxt;
  reg flag_ov_nxt;

  // ----------------------------------------
  // arithmetic
  // ----------------------------------------
  dec_sub_alu i_dec_sub_alu (
    .mem_val_in(mem_rdata_in),
    .acc_val_in(accumulator_reg_out),
    .carry_in(carry_in),
    .dec_out(dec_val),
    .dec_zero_out(dec_zero),
    .sub_out(sub_val),
    .sub_carry_out(sub_c),
    .sub_half_carry_out(sub_ac),
    .sub_ovf_out(sub_ov)
  );

  // ----------------------------------------
  // instruction acceptance
  // ----------------------------------------
  // the idle cycle after a skip ignores op_valid_in: the discarded slot
  // must not execute, so the fetch side sees busy_out high for it
  assign take = op_valid_in && (state_r == ST_EXEC);
  // whole-byte zero test: a zero operand wraps to all ones and does not skip
  assign skip_hit = take && op_dec_skip(op_in) && dec_zero;

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always @* begin
    state_nxt = ST_EXEC;
    case (state_r)
      ST_EXEC: begin
        if (skip_hit) begin
          state_nxt = ST_IDLE;
        end else begin
          state_nxt = ST_EXEC;
        end
      end
      ST_IDLE: begin
        state_nxt = ST_EXEC;
      end
      default: begin
        state_nxt = ST_EXEC;
      end
    endcase
  end

  // ----------------------------------------
  // pipeline control
  // ----------------------------------------
  always @* begin
    flush_nxt = `BIT_LOW;
    busy_nxt = `BIT_LOW;
    if ((state_r == ST_EXEC) && (state_nxt == ST_IDLE)) begin
      flush_nxt = `BIT_HIGH;
      busy_nxt = `BIT_HIGH;
    end
  end

  // ----------------------------------------
  // accumulator path
  // ----------------------------------------
  always @* begin
    acc_nxt = accumulator_reg_out;
    if (take && op_dec_skip(op_in) && !op_mem_write(op_in)) begin
      acc_nxt = dec_val;
    end
  end

  // ----------------------------------------
  // write-back path
  // ----------------------------------------
  always @* begin
    mem_we_nxt = `BIT_LOW;
    mem_addr_nxt = mem_addr_out;
    mem_wdata_nxt = mem_wdata_out;
    if (take) begin
      mem_addr_nxt = addr_in;
    end
    if (take && op_mem_write(op_in)) begin
      mem_we_nxt = `BIT_HIGH;
      if (op_dec_skip(op_in)) begin
        mem_wdata_nxt = dec_val;
      end else begin
        mem_wdata_nxt = sub_val;
      end
    end
  end

  // ----------------------------------------
  // flag path
  // ----------------------------------------
  // only the subtract updates flags; the decrement forms hold them
  always @* begin
    flag_we_nxt = `BIT_LOW;
    flag_z_nxt = flag_z_out;
    flag_c_nxt = flag_c_out;
    flag_ac_nxt = flag_ac_out;
    flag_ov_nxt = flag_ov_out;
    if (take && op_flag_write(op_in)) begin
      flag_we_nxt = `BIT_HIGH;
      flag_z_nxt = (sub_val == `BYTE_ZERO);
      flag_c_nxt = sub_c;
      flag_ac_nxt = sub_ac;
      flag_ov_nxt = sub_ov;
    end
  end

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_r <= ST_EXEC;
      flush_out <= `BIT_LOW;
      busy_out <= `BIT_LOW;
    end else begin
      state_r <= state_nxt;
      flush_out <= flush_nxt;
      busy_out <= busy_nxt;
    end
  end

  // ----------------------------------------
  // data registers
  // ----------------------------------------
  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      accumulator_reg_out <= `ACC_RESET;
      mem_we_out <= `BIT_LOW;
      mem_addr_out <= `BYTE_ZERO;
      mem_wdata_out <= `BYTE_ZERO;
    end else begin
      accumulator_reg_out <= acc_nxt;
      mem_we_out <= mem_we_nxt;
      mem_addr_out <= mem_addr_nxt;
      mem_wdata_out <= mem_wdata_nxt;
    end
  end

  // ----------------------------------------
  // flag registers
  // ----------------------------------------
  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      flag_we_out <= `BIT_LOW;
      flag_z_out <= `BIT_LOW;
      flag_c_out <= `BIT_LOW;
      flag_ac_out <= `BIT_LOW;
      flag_ov_out <= `BIT_LOW;
    end else begin
      flag_we_out <= flag_we_nxt;
      flag_z_out <= flag_z_nxt;
      flag_c_out <= flag_c_nxt;
      flag_ac_out <= flag_ac_nxt;
      flag_ov_out <= flag_ov_nxt;
    end
  end
endmodule

// ### testbench/dec_skip_asserts.sv
`timescale 1ns/1ns
// --
// checks
// --
module dec_skip_asserts (
  input wire core_clk_in,
  input wire rst_n_in,
  input wire op_valid_in,
  input wire [1:0] op_in,
  input wire [7:0] mem_rdata_in,
  input wire carry_in,
  input wire [7:0] accumulator_reg_out,
  input wire mem_we_out,
  input wire [7:0] mem_wdata_out,
  input wire flush_out,
  input wire busy_out,
  input wire flag_we_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  wire tk = op_valid_in && !busy_out;
  wire ds = tk && op_in[0] != op_in[1];
  property p_dec; tk && op_in == 2'h1 |=> mem_we_out && mem_wdata_out == $past(mem_rdata_in) - 8'h01; endproperty
  a_dec: assert property (p_dec) else $error("dec write");
  property p_skip; ds && mem_rdata_in == 8'h01 |=> flush_out && busy_out ##1 !busy_out; endproperty
  a_skip: assert property (p_skip) else $error("skip");
  property p_run; ds && mem_rdata_in != 8'h01 |=> !flush_out && !busy_out; endproperty
  a_run: assert property (p_run) else $error("run");
  property p_acc; tk && op_in == 2'h2 |=> !mem_we_out
    && accumulator_reg_out == $past(mem_rdata_in) - 8'h01; endproperty
  a_acc: assert property (p_acc) else $error("acc");
  property p_sub; tk && op_in == 2'h3 |=> mem_we_out && mem_wdata_out ==
    8'($past(accumulator_reg_out) + ~$past(mem_rdata_in) + $past(carry_in)); endproperty
  a_sub: assert property (p_sub) else $error("sub");
  property p_flag; ds |=> !flag_we_out; endproperty
  a_flag: assert property (p_flag) else $error("flags");
  c_skip: cover property (ds && mem_rdata_in == 8'h01);
  c_sub: cover property (tk && op_in == 2'h3);
  c_idle: cover property (busy_out && op_valid_in);
endmodule

// ### testbench/test_decrement_skip_execution.sv
`timescale 1ns/1ns
// --
// bench
// --
module test_decrement_skip_execution;
  reg core_clk_in = 1'b0;
  reg rst_n_in = 1'b0;
  reg op_valid_in = 1'b0;
  reg [1:0] op_in = 2'h0;
  reg [7:0] addr_in = 8'h00;
  reg [7:0] mem_rdata_in = 8'h00;
  reg carry_in = 1'b0;
  wire [7:0] acc_o, wd_o, ad_o;
  wire we_o, fl_o, bz_o, fw_o, z_o, c_o, ac_o, ov_o;
  int error_cnt = 0, checks = 0, rnd = 4, acc = 0, d, e_we, e_wd, e_fw, skip = 0;
  int e_ad = 0, s, fz = 0, fc = 0, fa = 0, fo = 0;
  always #5 core_clk_in = ~core_clk_in;
  decrement_skip_execution i_decrement_skip_execution (.core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in), .op_valid_in(op_valid_in), .op_in(op_in), .addr_in(addr_in),
    .mem_rdata_in(mem_rdata_in), .carry_in(carry_in), .accumulator_reg_out(acc_o),
    .mem_we_out(we_o), .mem_addr_out(ad_o), .mem_wdata_out(wd_o), .flush_out(fl_o),
    .busy_out(bz_o), .flag_we_out(fw_o), .flag_z_out(z_o), .flag_c_out(c_o),
    .flag_ac_out(ac_o), .flag_ov_out(ov_o));
  function automatic int xs(int x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction
  task chk(string n, logic [7:0] e, logic [7:0] g);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task close_out;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #20000;
    error_cnt++;
    close_out;
  end
  initial begin
    repeat (5) @(posedge core_clk_in);
    rst_n_in <= 1'b1;
    repeat (400) begin
      @(posedge core_clk_in);
      // a request during the idle cycle is ignored
      e_we = 0;
      e_fw = 0;
      d = (mem_rdata_in - 1) & 255;
      if (!skip && op_valid_in) e_ad = addr_in;
      if (skip) skip = 0;
      else if (op_valid_in && op_in == 1) begin
        e_we = 1;
        e_wd = d;
        skip = d == 0;
      end else if (op_valid_in && op_in == 2) begin
        acc = d;
        skip = d == 0;
      end else if (op_valid_in && op_in == 3) begin
        e_we = 1;
        e_fw = 1;
        s = acc + (~mem_rdata_in & 255) + carry_in;
        e_wd = s & 255;
        fz = e_wd == 0;
        fc = s >> 8;
        fa = ((acc & 15) + (~mem_rdata_in & 15) + carry_in) >> 4;
        fo = ((acc ^ mem_rdata_in) & (acc ^ e_wd) & 128) != 0;
      end
      rnd = xs(rnd);
      op_valid_in <= rnd[11] | rnd[12];
      op_in <= rnd[10:9];
      carry_in <= rnd[13];
      addr_in <= rnd[23:16];
      // 01 often, so skips come back to back with idle cycles
      mem_rdata_in <= rnd[8] ? 8'h01 : rnd[7:0];
      @(negedge core_clk_in);
      chk("mem_we", e_we, we_o);
      if (e_we) chk("wdata", e_wd, wd_o);
      chk("flush", skip, fl_o);
      chk("busy", skip, bz_o);
      chk("acc", acc, acc_o);
      chk("flag_we", e_fw, fw_o);
      chk("mem_addr", e_ad, ad_o);
      chk("flag_z", fz, z_o);
      chk("flag_c", fc, c_o);
      chk("flag_ac", fa, ac_o);
      chk("flag_ov", fo, ov_o);
    end
    close_out;
  end
endmodule
bind decrement_skip_execution dec_skip_asserts i_dec_skip_asserts (.core_clk_in(core_clk_in),
  .rst_n_in(rst_n_in), .op_valid_in(op_valid_in), .op_in(op_in), .mem_rdata_in(mem_rdata_in),
  .carry_in(carry_in), .accumulator_reg_out(accumulator_reg_out), .mem_we_out(mem_we_out),
  .mem_wdata_out(mem_wdata_out), .flush_out(flush_out), .busy_out(busy_out),
  .flag_we_out(flag_we_out));
